// ===== dhi_host_interface.sv
`timescale 1ns/1ps
//
// Contract
// [R1] monitor off: shared pin carries channel 39 output
// [R2] monitor on: selected channel 0..38 routed to shared pin
// [R3] interface select high: serial; protocol pin picks SPI or I2C
// [R4] interface select low: parallel bus interface
// [R5] parallel chip select is level sensitive, active low
// [R6] frame sync low starts counter; register updated after full bit count
// [R7] I2C address uses both hardware address pins
// [R8] parallel write on strobe rising edge with chip select low
// [R9] daisy-chain enable high in serial mode gives daisy-chain SPI
// [R10] parallel data bit 13 is MSB, bit 0 LSB
// [R11] six address lines select one of 40 channels
// [R12] register select picks data, offset, gain or special register
// [R13] readback shifts out on serial clock rise
// [R14] toggle mode bank pin picks A or B; normal mode uses A
// [R15] mode pins static; parallel strobes ignored in serial mode
module dhi_host_interface
    import dhi_pkg::*;
(
    input  wire logic                           clk,
    input  wire logic                           sys_rst,
    input  wire logic                           interface_select,
    input  wire logic                           protocol_select,
    input  wire logic                           chip_select_n,
    input  wire logic                           write_strobe_n,
    input  wire logic [dhi_pkg::DATA_W-1:0]     parallel_data_bus,
    input  wire logic [dhi_pkg::ADDR_W-1:0]     channel_address_bus,
    input  wire logic [dhi_pkg::REGSEL_W-1:0]   register_select,
    input  wire logic                           bank_select,
    input  wire logic                           toggle_mode,
    input  wire logic                           serial_clock,
    input  wire logic                           serial_data_in,
    input  wire logic                           i2c_addr_pin_lo,
    input  wire logic                           i2c_addr_pin_hi,
    input  wire logic                           monitor_enable,
    input  wire logic [dhi_pkg::MON_CH_W-1:0]   monitor_channel,
    input  wire logic [dhi_pkg::DATA_W-1:0]     readback_word,
    output dhi_pkg::dhi_mode_type               mode,
    output logic                                daisy_chain_active,
    output logic [6:0]                          i2c_address,
    output logic                                write_valid,
    output dhi_pkg::dhi_target_type             write_target,
    output logic [dhi_pkg::ADDR_W-1:0]          write_channel,
    output logic [dhi_pkg::DATA_W-1:0]          write_data,
    output logic                                write_bank_b,
    output logic                                serial_word_valid,
    output logic [dhi_pkg::FRAME_BITS-1:0]      serial_word,
    output logic                                serial_data_out,
    output logic                                serial_data_out_oe,
    output logic [dhi_pkg::MON_CH_W-1:0]        last_channel_output,
    output logic                                monitor_output
);
    localparam int SYNC_W = 9;
    localparam int SYNC_STAGES = 2;

    logic [SYNC_W-1:0] rawPins;
    logic [SYNC_W-1:0] syncPins;
    logic              sSel;
    logic              sProt;
    logic              sCsN;
    logic              sWrN;
    logic              sSclk;
    logic              sSdi;
    logic              sAdLo;
    logic              sAdHi;
    logic              sDcen;
    logic              wrPrev;
    logic              sclkPrev;
    logic              modeLatched;
    logic              framing;
    logic [CNT_W-1:0]  bitCount;
    logic [FRAME_BITS-1:0] shiftIn;
    logic [DATA_W-1:0] shiftOut;
    logic [DATA_W-1:0] parData;
    logic [ADDR_W-1:0] parAddr;
    logic [REGSEL_W-1:0] parReg;
    logic              parBank;
    logic              wrRise;
    logic              sclkRise;
    logic              sclkFall;
    logic              next_valid;
    logic [1:0]        settle;

    // the shared strobe pin doubles as daisy-chain enable in serial mode
    assign rawPins = {interface_select, protocol_select, chip_select_n, write_strobe_n,
                      serial_clock, serial_data_in, i2c_addr_pin_lo, i2c_addr_pin_hi, write_strobe_n};

    dhi_sync #(.W(SYNC_W)) u_sync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .din     (rawPins),
        .dout    (syncPins)
    );

    assign {sSel, sProt, sCsN, sWrN, sSclk, sSdi, sAdLo, sAdHi, sDcen} = syncPins;

    // bus lines are sampled two cycles late, matching the synchronised strobe
    logic [DATA_W-1:0]   dataQ1;
    logic [ADDR_W-1:0]   addrQ1;
    logic [REGSEL_W-1:0] regQ1;
    logic                bankQ1;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dataQ1  <= DATA_RESET;
            addrQ1  <= '0;
            regQ1   <= '0;
            bankQ1  <= 1'b0;
            parData <= DATA_RESET;
            parAddr <= '0;
            parReg  <= '0;
            parBank <= 1'b0;
        end else begin
            dataQ1  <= parallel_data_bus;           // see [R10]
            addrQ1  <= channel_address_bus;
            regQ1   <= register_select;
            bankQ1  <= bank_select;
            parData <= dataQ1;
            parAddr <= addrQ1;
            parReg  <= regQ1;
            parBank <= bankQ1;
        end
    end

    // the synchroniser shows its reset zeros first; straps must wait for real pin levels
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            settle <= '0;
        end else if (settle != 2'(SYNC_STAGES)) begin
            settle <= settle + 2'h1;
        end
    end

    // mode pins are straps: caught once after reset and held
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            modeLatched <= 1'b0;
            mode        <= DHI_MODE_PAR;
        end else if (!modeLatched && settle == 2'(SYNC_STAGES)) begin
            modeLatched <= 1'b1;                    // see [R15]
            if (!sSel)
                mode <= DHI_MODE_PAR;               // see [R4]
            else if (sProt)
                mode <= DHI_MODE_I2C;               // see [R3]
            else
                mode <= DHI_MODE_SPI;               // see [R3]
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            daisy_chain_active <= 1'b0;
            i2c_address        <= '0;
        end else begin
            daisy_chain_active <= (mode == DHI_MODE_SPI) && sDcen;   // see [R9]
            i2c_address        <= {I2C_ADDR_BASE, sAdHi, sAdLo};     // see [R7]
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wrPrev   <= 1'b1;
            sclkPrev <= 1'b0;
        end else begin
            wrPrev   <= sWrN;
            sclkPrev <= sSclk;
        end
    end

    assign wrRise   = sWrN && !wrPrev;
    assign sclkRise = sSclk && !sclkPrev;
    assign sclkFall = !sSclk && sclkPrev;
    // strobes in serial mode never reach the decode
    assign next_valid = wrRise && !sCsN && modeLatched && (mode == DHI_MODE_PAR); // see [R5] see [R8] see [R15]

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            write_valid   <= 1'b0;
            write_target  <= DHI_TGT_DATA;
            write_channel <= '0;
            write_data    <= DATA_RESET;
            write_bank_b  <= 1'b0;
        end else begin
            write_valid <= next_valid && (parAddr < ADDR_W'(NUM_CH));  // see [R11]
            if (next_valid) begin
                write_channel <= parAddr;                               // see [R11]
                write_data    <= parData;                               // see [R8]
                write_bank_b  <= toggle_mode && parBank;                // see [R14]
                unique case (parReg)                                    // see [R12]
                    REG_DATA:   write_target <= DHI_TGT_DATA;
                    REG_OFFSET: write_target <= DHI_TGT_OFFSET;
                    REG_GAIN:   write_target <= DHI_TGT_GAIN;
                    REG_SPECIAL: write_target <= DHI_TGT_SPECIAL;
                endcase
            end
        end
    end

    // frame counter; an early frame-sync release drops the partial word
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            framing           <= 1'b0;
            bitCount          <= '0;
            shiftIn           <= '0;
            serial_word_valid <= 1'b0;
            serial_word       <= '0;
        end else begin
            serial_word_valid <= 1'b0;
            if (mode != DHI_MODE_SPI || sCsN) begin
                framing  <= 1'b0;
                bitCount <= '0;
            end else begin
                framing <= 1'b1;                                        // see [R6]
                if (framing && sclkFall) begin
                    shiftIn <= {shiftIn[FRAME_BITS-2:0], sSdi};
                    if (bitCount == CNT_W'(FRAME_BITS - 1)) begin
                        bitCount          <= '0;
                        serial_word_valid <= 1'b1;                      // see [R6]
                        serial_word       <= {shiftIn[FRAME_BITS-2:0], sSdi};
                    end else begin
                        bitCount <= bitCount + CNT_W'(1);
                    end
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            shiftOut           <= '0;
            serial_data_out    <= 1'b0;
            serial_data_out_oe <= 1'b0;
        end else begin
            serial_data_out_oe <= (mode == DHI_MODE_SPI) && !sCsN;
            if (mode != DHI_MODE_SPI || sCsN) begin
                shiftOut <= readback_word;
            end else if (sclkRise) begin
                serial_data_out <= shiftOut[DATA_W-1];                  // see [R13]
                shiftOut        <= {shiftOut[DATA_W-2:0], 1'b0};
            end
        end
    end

    // the analog mux is abstracted to a channel index on the shared pin
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            last_channel_output <= MON_CH_W'(LAST_CH);
            monitor_output      <= 1'b0;
        end else if (monitor_enable && monitor_channel <= MON_CH_W'(MON_MAX_CH)) begin
            last_channel_output <= monitor_channel;                     // see [R2]
            monitor_output      <= 1'b1;
        end else begin
            last_channel_output <= MON_CH_W'(LAST_CH);                  // see [R1]
            monitor_output      <= 1'b0;
        end
    end

    a_par_write: assert property (@(posedge clk) disable iff (sys_rst)
        next_valid && parAddr < ADDR_W'(NUM_CH) |=> write_valid && write_data == $past(parData)) // see [R8]
        else $error("parallel write not issued");
    a_serial_no_write: assert property (@(posedge clk) disable iff (sys_rst)
        mode != DHI_MODE_PAR |=> !write_valid) // see [R15]
        else $error("write in serial mode");
    a_cs_gates: assert property (@(posedge clk) disable iff (sys_rst)
        $past(sCsN) |-> !write_valid) // see [R5]
        else $error("write without chip select");
    a_addr_range: assert property (@(posedge clk) disable iff (sys_rst)
        write_valid |-> write_channel < ADDR_W'(NUM_CH)) // see [R11]
        else $error("channel out of range");
    a_mon_off: assert property (@(posedge clk) disable iff (sys_rst)
        !monitor_enable |=> last_channel_output == MON_CH_W'(LAST_CH) && !monitor_output) // see [R1]
        else $error("shared pin not channel 39");
    a_mon_on: assert property (@(posedge clk) disable iff (sys_rst)
        monitor_enable && monitor_channel <= MON_CH_W'(MON_MAX_CH) |=> monitor_output
        && last_channel_output == $past(monitor_channel)) // see [R2]
        else $error("monitor route wrong");
    a_daisy: assert property (@(posedge clk) disable iff (sys_rst)
        daisy_chain_active |-> mode == DHI_MODE_SPI) // see [R9]
        else $error("daisy chain outside SPI");
    a_i2c_addr: assert property (@(posedge clk) disable iff (sys_rst)
        ##1 i2c_address[1:0] == $past({sAdHi, sAdLo})) // see [R7]
        else $error("i2c address pins lost");
    a_bank_norm: assert property (@(posedge clk) disable iff (sys_rst)
        next_valid && !toggle_mode |=> !write_bank_b) // see [R14]
        else $error("bank B in normal mode");
    a_mode_stable: assert property (@(posedge clk) disable iff (sys_rst)
        modeLatched |=> $stable(mode)) // see [R3] see [R4]
        else $error("mode changed after strap");
    a_frame_abort: assert property (@(posedge clk) disable iff (sys_rst)
        sCsN |=> !serial_word_valid) // see [R6]
        else $error("word without frame sync");
    a_sdo_hold: assert property (@(posedge clk) disable iff (sys_rst)
        !sclkRise && serial_data_out_oe && $past(serial_data_out_oe) |=> $stable(serial_data_out)) // see [R13]
        else $error("sdo changed off rising edge");

    sequence s_strobe_rise;
        wrRise && !sCsN && modeLatched && mode == DHI_MODE_PAR;
    endsequence
    sequence s_write_pulse;
        write_valid ##1 !write_valid;
    endsequence
    a_strobe_write: assert property (@(posedge clk) disable iff (sys_rst)
        s_strobe_rise ##0 parAddr < ADDR_W'(NUM_CH) |=> s_write_pulse) // see [R8]
        else $error("strobe did not give one write pulse");
    a_sdo_drive: assert property (@(posedge clk) disable iff (sys_rst)
        mode != DHI_MODE_SPI |=> !serial_data_out_oe) // see [R13]
        else $error("serial output driven outside SPI");
    a_strap_wait: assert property (@(posedge clk) disable iff (sys_rst)
        settle != 2'(SYNC_STAGES) |=> mode == DHI_MODE_PAR) // see [R15]
        else $error("strap taken before synchroniser filled");
endmodule : dhi_host_interface

// ===== dhi_host_model.sv
`timescale 1ns/1ps
module dhi_host_model (
    input  wire logic                        clk,
    output logic                             chipSelectN,
    output logic                             writeStrobeN,
    output logic [dhi_pkg::DATA_W-1:0]       dataBus,
    output logic [dhi_pkg::ADDR_W-1:0]       channelAddress,
    output logic [dhi_pkg::REGSEL_W-1:0]     registerSel,
    output logic                             bankSel,
    output logic                             serialClock,
    output logic                             serialData
);
    import dhi_pkg::*;
    initial begin
        chipSelectN = 1'b1;
        writeStrobeN = 1'b1;
        dataBus = 14'h0000;
        channelAddress = 6'h3f;
        registerSel = 2'h0;
        bankSel = 1'b0;
        serialClock = 1'b0;
        serialData = 1'b0;
    end
    // strobe level doubles as the daisy-chain enable in serial mode
    task automatic setStrobe(input logic lvl);
        @(posedge clk);
        writeStrobeN <= lvl;
        repeat (4) @(posedge clk);
    endtask : setStrobe
    task automatic parWrite(input logic [5:0] ch, input logic [1:0] rs, input logic [13:0] d, input logic bk);
        @(posedge clk);
        chipSelectN <= 1'b0;
        channelAddress <= ch;
        registerSel <= rs;
        dataBus <= d;
        bankSel <= bk;
        writeStrobeN <= 1'b0;
        repeat (4) @(posedge clk);
        writeStrobeN <= 1'b1;
        repeat (5) @(posedge clk);
        chipSelectN <= 1'b1;
        // released data, address and bank lines show the inverse so stale values cannot pass
        dataBus <= ~d;
        channelAddress <= ~ch;
        bankSel <= ~bk;
        repeat (3) @(posedge clk);
    endtask : parWrite
    task automatic spiFrame(input logic [23:0] w);
        int i;
        @(posedge clk);
        chipSelectN <= 1'b0;
        repeat (3) @(posedge clk);
        for (i = 23; i >= 0; i--) begin
            serialData <= w[i];
            serialClock <= 1'b1;
            repeat (3) @(posedge clk);
            serialClock <= 1'b0;
            repeat (3) @(posedge clk);
        end
        repeat (6) @(posedge clk);
        chipSelectN <= 1'b1;
        serialData <= ~w[0];
        repeat (3) @(posedge clk);
    endtask : spiFrame
endmodule : dhi_host_model

// ===== dhi_pkg.sv
package dhi_pkg;
    localparam int DATA_W      = 14;
    localparam int ADDR_W      = 6;
    localparam int REGSEL_W    = 2;
    localparam int NUM_CH      = 40;
    localparam int MON_CH_W    = 6;
    localparam int LAST_CH     = 39;
    localparam int MON_MAX_CH  = 38;
    localparam int FRAME_BITS  = 24;
    localparam int CNT_W       = 5;
    localparam int I2C_BASE_W  = 5;
    // arbitrary neutral upper address bits
    localparam logic [I2C_BASE_W-1:0] I2C_ADDR_BASE = 5'h15;

    localparam logic [REGSEL_W-1:0] REG_SPECIAL = 2'h0;
    localparam logic [REGSEL_W-1:0] REG_GAIN    = 2'h1;
    localparam logic [REGSEL_W-1:0] REG_OFFSET  = 2'h2;
    localparam logic [REGSEL_W-1:0] REG_DATA    = 2'h3;

    localparam logic [DATA_W-1:0]   DATA_RESET  = 14'h0000;

    typedef enum logic [1:0] {
        DHI_MODE_PAR,
        DHI_MODE_SPI,
        DHI_MODE_I2C
    } dhi_mode_type;

    typedef enum logic [1:0] {
        DHI_TGT_SPECIAL,
        DHI_TGT_GAIN,
        DHI_TGT_OFFSET,
        DHI_TGT_DATA
    } dhi_target_type;
endpackage : dhi_pkg

// ===== dhi_sync.sv
`timescale 1ns/1ps
module dhi_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] stage;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stage <= '0;
            dout  <= '0;
        end else begin
            stage <= din;
            dout  <= stage;
        end
    end
endmodule : dhi_sync

// ===== testbench.sv
`timescale 1ns/1ps
module testbench;
    import dhi_pkg::*;
    logic clk = 1'b0, sysRst = 1'b1, ifSel = 1'b0, protSel = 1'b0, togMode = 1'b0, adLo = 1'b0, adHi = 1'b0;
    logic monEn = 1'b0;
    logic [5:0] monCh = 6'h00;
    logic [13:0] rbWord = 14'h0000;
    logic csN, wrN, bank, sclk, sdi, daisy, wv, wb, swv, sdo, sdoOe, monOut;
    logic [13:0] pdata, wdata;
    logic [5:0] addr, wch, lastCh;
    logic [1:0] rsel;
    logic [6:0] i2cAddr;
    logic [23:0] sword;
    dhi_mode_type mode;
    dhi_target_type wtgt;
    int mismatches = 0, numChecks = 0, cycles = 0, seed = 6;
    logic [22:0] expW[$];
    logic [23:0] expS[$];
    initial forever #25 clk = ~clk;
    dhi_host_model host (.clk(clk), .chipSelectN(csN), .writeStrobeN(wrN), .dataBus(pdata),
        .channelAddress(addr), .registerSel(rsel), .bankSel(bank), .serialClock(sclk), .serialData(sdi));
    dhi_host_interface DUT (.clk(clk), .sys_rst(sysRst), .interface_select(ifSel), .protocol_select(protSel),
        .chip_select_n(csN), .write_strobe_n(wrN), .parallel_data_bus(pdata), .channel_address_bus(addr),
        .register_select(rsel), .bank_select(bank), .toggle_mode(togMode), .serial_clock(sclk),
        .serial_data_in(sdi), .i2c_addr_pin_lo(adLo), .i2c_addr_pin_hi(adHi), .monitor_enable(monEn),
        .monitor_channel(monCh), .readback_word(rbWord), .mode(mode), .daisy_chain_active(daisy),
        .i2c_address(i2cAddr), .write_valid(wv), .write_target(wtgt), .write_channel(wch),
        .write_data(wdata), .write_bank_b(wb), .serial_word_valid(swv), .serial_word(sword),
        .serial_data_out(sdo), .serial_data_out_oe(sdoOe), .last_channel_output(lastCh),
        .monitor_output(monOut));
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] expd);
        numChecks++;
        if (seen !== expd) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, expd, seen);
        end
    endtask : check
    task automatic final_report;
        $display("checks %0d mismatches %0d", numChecks, mismatches);
        if (mismatches == 0 && numChecks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report
    function automatic dhi_target_type tgtOf(input logic [1:0] rs);
        case (rs)
            REG_DATA:   return DHI_TGT_DATA;
            REG_OFFSET: return DHI_TGT_OFFSET;
            REG_GAIN:   return DHI_TGT_GAIN;
            default:    return DHI_TGT_SPECIAL;
        endcase
    endfunction : tgtOf
    task automatic doReset(input logic s, input logic p, input logic lo, input logic hi);
        @(posedge clk);
        sysRst <= 1'b1;
        ifSel <= s;
        protSel <= p;
        adLo <= lo;
        adHi <= hi;
        repeat (4) @(posedge clk);
        sysRst <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
    endtask : doReset
    task automatic readCheck(input logic [13:0] rb);
        @(posedge sclk);
        repeat (4) @(posedge clk);
        #1;
        check("readback msb", 24'(sdo), 24'(rb[13]));
        check("readback drive", 24'(sdoOe), 24'h1);
    endtask : readCheck
    // model side: every write pulse must match the oldest accepted write
    always @(posedge clk) begin
        if (wv === 1'b1) begin
            if (expW.size() == 0) check("unexpected write", 24'h1, 24'h0);
            else check("write fields", 24'({wtgt, wch, wdata, wb}), 24'(expW.pop_front()));
        end
        if (swv === 1'b1) begin
            if (expS.size() == 0) check("unexpected word", 24'h1, 24'h0);
            else check("serial word", sword, expS.pop_front());
        end
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            final_report();
        end
    end
    initial begin
        int i;
        logic [5:0] ch;
        logic [13:0] d;
        logic [23:0] w;
        logic en, bk, tg;
        doReset(1'b0, 1'b0, 1'b0, 1'b0);
        check("mode", 24'(mode), 24'(DHI_MODE_PAR));
        check("daisy in parallel", 24'(daisy), 24'h0);
        for (i = 0; i < 12; i++) begin
            ch = (i == 0) ? 6'h00 : (i == 1) ? 6'h27 : (i == 2) ? 6'h28 : (i == 3) ? 6'h3f : 6'($random(seed));
            d = 14'($random(seed));
            bk = 1'($random(seed));
            tg = i[2];
            @(posedge clk);
            togMode <= tg;
            if (ch < NUM_CH) expW.push_back({tgtOf(2'(i)), ch, d, tg & bk});
            host.parWrite(ch, 2'(i), d, bk);
        end
        check("pending writes", 24'(expW.size()), 24'h0);
        for (i = 0; i < 10; i++) begin
            en = i[0];
            ch = (i == 3) ? 6'h26 : (i == 5) ? 6'h27 : (i == 7) ? 6'h00 : 6'($random(seed));
            @(posedge clk);
            monEn <= en;
            monCh <= ch;
            repeat (3) @(posedge clk);
            #1;
            check("shared pin channel", 24'(lastCh), (en && ch <= MON_MAX_CH) ? 24'(ch) : 24'(LAST_CH));
            check("monitor routing", 24'(monOut), 24'(en && ch <= MON_MAX_CH));
        end
        $display("test parallel and monitor done");
        doReset(1'b1, 1'b0, 1'b0, 1'b0);
        check("mode", 24'(mode), 24'(DHI_MODE_SPI));
        host.setStrobe(1'b1);
        check("daisy on", 24'(daisy), 24'h1);
        host.setStrobe(1'b0);
        check("daisy off", 24'(daisy), 24'h0);
        host.parWrite(6'h05, REG_DATA, 14'h1abc, 1'b0);
        host.setStrobe(1'b0);
        for (i = 0; i < 3; i++) begin
            w = 24'($random(seed));
            d = 14'($random(seed));
            expS.push_back(w);
            @(posedge clk);
            rbWord <= d;
            fork
                host.spiFrame(w);
                readCheck(d);
            join
            #1;
            check("drive released", 24'(sdoOe), 24'h0);
        end
        check("pending words", 24'(expS.size()), 24'h0);
        $display("test serial done");
        for (i = 0; i < 4; i++) begin
            doReset(1'b1, 1'b1, i[0], i[1]);
            check("mode", 24'(mode), 24'(DHI_MODE_I2C));
            check("i2c address", 24'(i2cAddr), 24'({I2C_ADDR_BASE, i[1], i[0]}));
        end
        $display("test i2c done");
        final_report();
    end
endmodule : testbench
